//--- rtl/dbot_mem.sv
// Memory end: burst sizing, latencies, read/write beats and termination mode
`timescale 1ns/1ps
// Behaviour
// - Field 00, or 01 with A12 high: eight beats
// - Field 10 forces four-beat chop always
// - Field 01, A12 low: chop this command
// - Controller waits write-to-read after last beat
// - Controller waits write recovery before precharge
// - Chopped write timing counts as eight beats
// - Power-down entry follows only safe commands; the controller only refuses it while no bank is open
// - Termination held high four-beat hold minimum
// - After write, hold four or eight interval
// - Hold measured from assertion and write
// - Termination async period is write latency minus one
// - Read/write latency include additive latency
module dbot_mem #(
    parameter int CAS_LATENCY = dbot_pkg::DBOT_CAS_LATENCY,
    parameter int CAS_WRITE_LATENCY = dbot_pkg::DBOT_CAS_WRITE_LATENCY,
    parameter int ADDITIVE_LATENCY = dbot_pkg::DBOT_ADDITIVE_LATENCY
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Link
    dbot_link_if.mem link,
    // User side: captured write data and read data source
    output logic wr_valid_o,
    output logic [dbot_pkg::DBOT_DQ_W-1:0] wr_data_o,
    input wire logic wr_ready_i,
    input wire logic [dbot_pkg::DBOT_DQ_W-1:0] rd_data_i,
    output logic [1:0] burst_len_o,
    output logic powered_down_o
);
    import dbot_pkg::*;

    // ----------------------------------------
    // Latencies
    // ----------------------------------------
    localparam int READ_LATENCY = ADDITIVE_LATENCY + CAS_LATENCY;
    localparam int WRITE_LATENCY = ADDITIVE_LATENCY + CAS_WRITE_LATENCY;
    localparam int TERM_ASYNC_TRANSITION = WRITE_LATENCY - 1;
    localparam int PIPE = 32;

    logic [1:0] bl_field;
    logic [PIPE-1:0] rd_pipe;
    logic [PIPE-1:0] wr_pipe;
    logic rd_chop;
    logic wr_chop;
    logic cmd_chop;
    logic [3:0] rd_beats;
    logic [3:0] wr_beats;
    logic [5:0] anpd_cnt;
    logic pd;

    // ----------------------------------------
    // Burst size decode
    // ----------------------------------------
    always_comb begin
        cmd_chop = 1'b0;
        if (bl_field == DBOT_BL_FIXED4) begin
            cmd_chop = 1'b1;
        end else if (bl_field == DBOT_BL_OTF) begin
            cmd_chop = ~link.addr[DBOT_A12_BIT];
        end else begin
            cmd_chop = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bl_field <= DBOT_BL_RESET;
        end else if (link.cmd == DBOT_CMD_MRS && link.bank == 3'h0) begin
            bl_field <= link.addr[DBOT_BL_LSB +: 2];
        end
    end

    // ----------------------------------------
    // Latency pipes
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_pipe <= '0;
            wr_pipe <= '0;
        end else begin
            rd_pipe <= {rd_pipe[PIPE-2:0], link.cmd == DBOT_CMD_READ};
            wr_pipe <= {wr_pipe[PIPE-2:0], link.cmd == DBOT_CMD_WRITE};
        end
    end

    // ----------------------------------------
    // Read beats, driven at read latency after command
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_chop <= 1'b0;
            rd_beats <= 4'h0;
            link.dq_mem <= 16'h0000;
            link.dq_mem_oe <= 1'b0;
            link.strobe_mem <= 1'b0;
        end else begin
            if (link.cmd == DBOT_CMD_READ) begin
                rd_chop <= cmd_chop;
            end
            if (rd_pipe[READ_LATENCY-2]) begin
                rd_beats <= rd_chop ? 4'(DBOT_BEATS4) : 4'(DBOT_BEATS8);
            end else if (rd_beats != 4'h0) begin
                rd_beats <= rd_beats - 4'h1;
            end
            link.dq_mem_oe <= rd_pipe[READ_LATENCY-2] || rd_beats > 4'h1;
            link.dq_mem <= rd_data_i;
            link.strobe_mem <= (rd_pipe[READ_LATENCY-2] || rd_beats > 4'h1) ? ~link.strobe_mem : 1'b0;
        end
    end

    // ----------------------------------------
    // Write capture at write latency; a chopped burst still occupies eight beats
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_chop <= 1'b0;
            wr_beats <= 4'h0;
            wr_valid_o <= 1'b0;
            wr_data_o <= 16'h0000;
        end else begin
            if (link.cmd == DBOT_CMD_WRITE) begin
                wr_chop <= cmd_chop;
            end
            if (wr_pipe[WRITE_LATENCY-1]) begin
                wr_beats <= 4'(DBOT_BEATS8);
            end else if (wr_beats != 4'h0) begin
                wr_beats <= wr_beats - 4'h1;
            end
            // Only the first four slots carry data when chopped
            wr_valid_o <= (wr_pipe[WRITE_LATENCY-1] || (wr_beats > 4'h1 && (!wr_chop || wr_beats > 4'h5)))
                          && link.dq_ctl_oe;
            wr_data_o <= link.dq;
        end
    end

    // ----------------------------------------
    // Power-down and async termination transition
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pd <= 1'b0;
            anpd_cnt <= 6'h00;
            link.term_async <= 1'b0;
        end else begin
            // One less loaded: the flag is registered once more after the count
            if (link.cmd == DBOT_CMD_PDE) begin
                pd <= 1'b1;
                anpd_cnt <= 6'(TERM_ASYNC_TRANSITION - 1);
            end else if (link.cmd == DBOT_CMD_PDX) begin
                pd <= 1'b0;
                anpd_cnt <= 6'(TERM_ASYNC_TRANSITION - 1);
            end else if (anpd_cnt != 6'h00) begin
                anpd_cnt <= anpd_cnt - 6'h01;
            end
            // Exit mirrors entry: stays asynchronous until the period runs out
            link.term_async <= pd ? anpd_cnt <= 6'h01 : anpd_cnt > 6'h01;
        end
    end

    assign burst_len_o = bl_field;
    assign powered_down_o = pd;
endmodule

//--- rtl/dbot_pkg.sv
// Shared constants and types for the memory command link
package dbot_pkg;
    // ----------------------------------------
    // Command encodings
    // ----------------------------------------
    typedef enum logic [2:0] {
        DBOT_CMD_NOP   = 3'h0,
        DBOT_CMD_ACT   = 3'h1,
        DBOT_CMD_WRITE = 3'h2,
        DBOT_CMD_READ  = 3'h3,
        DBOT_CMD_PRE   = 3'h4,
        DBOT_CMD_MRS   = 3'h5,
        DBOT_CMD_PDE   = 3'h6,
        DBOT_CMD_PDX   = 3'h7
    } dbot_cmd_t;

    // ----------------------------------------
    // Mode register zero burst-length field
    // ----------------------------------------
    localparam logic [1:0] DBOT_BL_FIXED8 = 2'h0;
    localparam logic [1:0] DBOT_BL_OTF = 2'h1;
    localparam logic [1:0] DBOT_BL_FIXED4 = 2'h2;
    localparam int DBOT_BL_LSB = 0;
    localparam int DBOT_A12_BIT = 12;
    localparam logic [1:0] DBOT_BL_RESET = 2'h0;

    // ----------------------------------------
    // Widths and latencies
    // ----------------------------------------
    localparam int DBOT_DQ_W = 16;
    localparam int DBOT_ADDR_W = 14;
    localparam int DBOT_BANK_W = 3;
    localparam int DBOT_NBANK = 8;
    localparam int DBOT_CAS_LATENCY = 5;
    localparam int DBOT_CAS_WRITE_LATENCY = 5;
    localparam int DBOT_ADDITIVE_LATENCY = 0;
    localparam int DBOT_BEATS8 = 8;
    localparam int DBOT_BEATS4 = 4;
    localparam int DBOT_TERM_HOLD_FOUR = 4;
    localparam int DBOT_TERM_HOLD_EIGHT = 6;
    localparam int DBOT_WTR_CK = 4;
    localparam int DBOT_WR_CK = 8;
endpackage

//--- rtl/dbot_link_if.sv
// Command, data and termination link between controller and memory
`timescale 1ns/1ps
interface dbot_link_if;
    import dbot_pkg::*;
    dbot_cmd_t cmd;
    logic [dbot_pkg::DBOT_ADDR_W-1:0] addr;
    logic [dbot_pkg::DBOT_BANK_W-1:0] bank;
    logic term_ctl;
    logic [dbot_pkg::DBOT_DQ_W-1:0] dq_ctl;
    logic dq_ctl_oe;
    logic [dbot_pkg::DBOT_DQ_W-1:0] dq_mem;
    logic dq_mem_oe;
    logic strobe_ctl;
    logic strobe_mem;
    logic term_async;
    logic [dbot_pkg::DBOT_DQ_W-1:0] dq;
    assign dq = dq_mem_oe ? dq_mem : dq_ctl;

    modport ctl (output cmd, output addr, output bank, output term_ctl, output dq_ctl, output dq_ctl_oe,
                 output strobe_ctl, input dq, input dq_mem_oe, input strobe_mem, input term_async);
    modport mem (input cmd, input addr, input bank, input term_ctl, input dq, input dq_ctl_oe, input strobe_ctl,
                 output dq_mem, output dq_mem_oe, output strobe_mem, output term_async);
endinterface

//--- rtl/dbot_ctl.sv
// Controller end: command issue, data buffering and termination hold
`timescale 1ns/1ps
module dbot_ctl #(
    parameter int CAS_WRITE_LATENCY = dbot_pkg::DBOT_CAS_WRITE_LATENCY,
    parameter int ADDITIVE_LATENCY = dbot_pkg::DBOT_ADDITIVE_LATENCY
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // User request
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire dbot_pkg::dbot_cmd_t req_cmd_i,
    input wire logic [dbot_pkg::DBOT_ADDR_W-1:0] req_addr_i,
    input wire logic [dbot_pkg::DBOT_BANK_W-1:0] req_bank_i,
    input wire logic req_chop_i,
    // Write data
    input wire logic wd_valid_i,
    output logic wd_ready_o,
    input wire logic [dbot_pkg::DBOT_DQ_W-1:0] wd_data_i,
    // Link
    dbot_link_if.ctl link
);
    import dbot_pkg::*;
    localparam int WRITE_LATENCY = ADDITIVE_LATENCY + CAS_WRITE_LATENCY;

    // ----------------------------------------
    // Two-entry write data buffer
    // ----------------------------------------
    logic [DBOT_DQ_W-1:0] buf_mem [2];
    logic [1:0] buf_cnt;
    logic buf_rd;
    logic buf_wr;
    logic buf_rp;
    logic buf_wp;
    assign wd_ready_o = buf_cnt != 2'h2;
    assign buf_wr = wd_valid_i && wd_ready_o;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            buf_cnt <= 2'h0;
            buf_rp <= 1'b0;
            buf_wp <= 1'b0;
        end else begin
            buf_cnt <= buf_cnt + 2'(buf_wr) - 2'(buf_rd);
            if (buf_wr) buf_wp <= ~buf_wp;
            if (buf_rd) buf_rp <= ~buf_rp;
        end
    end
    always_ff @(posedge clock_i) begin
        if (buf_wr) buf_mem[buf_wp] <= wd_data_i;
    end

    // ----------------------------------------
    // Timers: hold-off after writes, termination hold
    // ----------------------------------------
    logic [5:0] wtr_cnt;
    logic [5:0] wr_cnt;
    logic [5:0] term_cnt;
    logic [5:0] wbeat;
    logic issue;
    logic bank_open;
    logic legal;
    always_comb begin
        legal = 1'b1;
        if (req_cmd_i == DBOT_CMD_READ && wtr_cnt != 6'h00) legal = 1'b0;
        if (req_cmd_i == DBOT_CMD_PRE && wr_cnt != 6'h00) legal = 1'b0;
        if (req_cmd_i == DBOT_CMD_PDE && !bank_open) legal = 1'b0;
        if (req_cmd_i == DBOT_CMD_WRITE && (buf_cnt == 2'h0 || wbeat != 6'h00)) legal = 1'b0;
    end
    assign req_ready_o = legal;
    assign issue = req_valid_i && legal;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link.cmd <= DBOT_CMD_NOP;
            link.addr <= '0;
            link.bank <= '0;
            bank_open <= 1'b0;
        end else begin
            link.cmd <= issue ? req_cmd_i : DBOT_CMD_NOP;
            link.addr <= req_addr_i;
            link.bank <= req_bank_i;
            if (issue && req_cmd_i == DBOT_CMD_WRITE) link.addr[DBOT_A12_BIT] <= ~req_chop_i;
            if (issue && req_cmd_i == DBOT_CMD_ACT) bank_open <= 1'b1;
            else if (issue && req_cmd_i == DBOT_CMD_PRE) bank_open <= 1'b0;
        end
    end

    // Write beats from buffer, eight-slot window even when chopped
    assign buf_rd = wbeat != 6'h00 && wbeat <= 6'h08 && buf_cnt != 2'h0;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wbeat <= 6'h00;
            wtr_cnt <= 6'h00;
            wr_cnt <= 6'h00;
            term_cnt <= 6'h00;
            link.term_ctl <= 1'b0;
            link.dq_ctl <= 16'h0000;
            link.dq_ctl_oe <= 1'b0;
            link.strobe_ctl <= 1'b0;
        end else begin
            if (issue && req_cmd_i == DBOT_CMD_WRITE) begin
                // One short, as the beat is registered once more on its way to the link
                wbeat <= 6'(WRITE_LATENCY + DBOT_BEATS8 - 1);
                // Counts start after a full eight-beat slot either way
                wtr_cnt <= 6'(WRITE_LATENCY + DBOT_BEATS8 + DBOT_WTR_CK);
                wr_cnt <= 6'(WRITE_LATENCY + DBOT_BEATS8 + DBOT_WR_CK);
                link.term_ctl <= 1'b1;
                term_cnt <= req_chop_i ? 6'(DBOT_TERM_HOLD_FOUR) : 6'(DBOT_TERM_HOLD_EIGHT);
            end else begin
                if (wbeat != 6'h00) wbeat <= wbeat - 6'h01;
                if (wtr_cnt != 6'h00) wtr_cnt <= wtr_cnt - 6'h01;
                if (wr_cnt != 6'h00) wr_cnt <= wr_cnt - 6'h01;
                if (term_cnt != 6'h00) term_cnt <= term_cnt - 6'h01;
                else if (wbeat == 6'h00) link.term_ctl <= 1'b0;
            end
            link.dq_ctl_oe <= buf_rd;
            link.dq_ctl <= buf_mem[buf_rp];
            link.strobe_ctl <= buf_rd ? ~link.strobe_ctl : 1'b0;
        end
    end
endmodule

//--- dv/dbot_link_checker.sv
// Timing assertions on the controller to memory link
`timescale 1ns/1ps
module dbot_link_checker (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Link signals
    input wire dbot_pkg::dbot_cmd_t cmd,
    input wire logic term_ctl,
    input wire logic dq_ctl_oe,
    input wire logic dq_mem_oe,
    input wire logic term_async
);
    import dbot_pkg::*;
    localparam int WRITE_LATENCY = DBOT_ADDITIVE_LATENCY + DBOT_CAS_WRITE_LATENCY;
    localparam int READ_LATENCY = DBOT_ADDITIVE_LATENCY + DBOT_CAS_LATENCY;
    localparam int READ_LATENCY_M1 = READ_LATENCY - 1;
    int wtr_cnt;
    int wr_cnt;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    // ----------------------------------------
    // Recovery windows
    // ----------------------------------------
    // Chopped writes load the full-burst span, so one counter serves both
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wtr_cnt <= 0;
        end else if (cmd == DBOT_CMD_WRITE) begin
            wtr_cnt <= WRITE_LATENCY + DBOT_BEATS8 + DBOT_WTR_CK - 1;
        end else if (wtr_cnt > 0) begin
            wtr_cnt <= wtr_cnt - 1;
        end
    end
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_cnt <= 0;
        end else if (cmd == DBOT_CMD_WRITE) begin
            wr_cnt <= WRITE_LATENCY + DBOT_BEATS8 + DBOT_WR_CK - 1;
        end else if (wr_cnt > 0) begin
            wr_cnt <= wr_cnt - 1;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_wtr; cmd == DBOT_CMD_READ |-> wtr_cnt == 0; endproperty
    a_wtr: assert property (p_wtr)
        else $error("read too soon after write");
    property p_wr_rec; cmd == DBOT_CMD_PRE |-> wr_cnt == 0; endproperty
    a_wr_rec: assert property (p_wr_rec)
        else $error("precharge inside write recovery");
    property p_term_hold; $rose(term_ctl) |-> term_ctl [*4]; endproperty
    a_term_hold: assert property (p_term_hold)
        else $error("termination hold too short");
    property p_term_wr; cmd == DBOT_CMD_WRITE |-> term_ctl [*8]; endproperty
    a_term_wr: assert property (p_term_wr)
        else $error("termination dropped after write");
    property p_wr_lat; cmd == DBOT_CMD_WRITE |-> ##WRITE_LATENCY dq_ctl_oe; endproperty
    a_wr_lat: assert property (p_wr_lat)
        else $error("write data not at write latency");
    property p_rd_lat; cmd == DBOT_CMD_READ |-> ##READ_LATENCY_M1 !dq_mem_oe ##1 dq_mem_oe; endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read data not at read latency");
    property p_pd_in; cmd == DBOT_CMD_PDE |-> !term_async ##[3:5] term_async; endproperty
    a_pd_in: assert property (p_pd_in)
        else $error("async termination period wrong on entry");
    property p_pd_out; cmd == DBOT_CMD_PDX |-> ##[1:5] !term_async; endproperty
    a_pd_out: assert property (p_pd_out)
        else $error("async termination kept after exit");
    c_write: cover property (cmd == DBOT_CMD_WRITE);
    c_read: cover property (cmd == DBOT_CMD_READ);
    c_pde: cover property (cmd == DBOT_CMD_PDE);
endmodule

//--- dv/test_ddr3_burst_and_odt_timing.sv
// Testbench joining the controller and memory ends over the link
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module test_ddr3_burst_and_odt_timing;
    import dbot_pkg::*;
    localparam int WRITE_LATENCY = DBOT_ADDITIVE_LATENCY + DBOT_CAS_WRITE_LATENCY;
    localparam logic [DBOT_DQ_W-1:0] RD_WORD = 16'hA5C3;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    dbot_cmd_t req_cmd_i = DBOT_CMD_NOP;
    logic [DBOT_ADDR_W-1:0] req_addr_i = 14'h0000;
    logic req_chop_i = 1'b0;
    logic wd_valid_i = 1'b0;
    logic wd_took = 1'b0;
    logic [DBOT_DQ_W-1:0] wd_data_i = 16'h1000;
    logic req_ready_o;
    logic wd_ready_o;
    logic wr_valid_o;
    logic powered_down_o;
    logic [DBOT_DQ_W-1:0] wr_data_o;
    logic [1:0] burst_len_o;
    logic [1:0] mode_tab [6] = '{DBOT_BL_FIXED8, DBOT_BL_FIXED8, DBOT_BL_OTF, DBOT_BL_OTF,
                                 DBOT_BL_FIXED4, DBOT_BL_FIXED4};
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_cap = 0;
    int n_rb = 0;
    int t_acc = 0;
    int tw = 0;
    int beats = 0;
    always #2.5 clock_i = ~clock_i;
    dbot_link_if link ();
    dbot_ctl dbot_ctl_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i), .req_bank_i(3'h0),
        .req_chop_i(req_chop_i), .wd_valid_i(wd_valid_i), .wd_ready_o(wd_ready_o), .wd_data_i(wd_data_i),
        .link(link.ctl));
    dbot_mem dbot_mem_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .link(link.mem),
        .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o), .wr_ready_i(1'b1), .rd_data_i(RD_WORD),
        .burst_len_o(burst_len_o), .powered_down_o(powered_down_o));
    dbot_link_checker dbot_link_checker_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmd(link.cmd),
        .term_ctl(link.term_ctl), .dq_ctl_oe(link.dq_ctl_oe), .dq_mem_oe(link.dq_mem_oe),
        .term_async(link.term_async));
    // ----------------------------------------
    // Monitors and write-data source
    // ----------------------------------------
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        wd_took <= wd_valid_i && wd_ready_o;
        if (wr_valid_o === 1'b1) begin
            n_cap <= n_cap + 1;
            // Every burst takes eight fresh words, so the low bits name the slot
            `CHK(wr_data_o[2:0], n_cap[2:0])
        end
        if (link.dq_mem_oe === 1'b1) begin
            n_rb <= n_rb + 1;
            `CHK(link.dq, RD_WORD)
            `CHK(link.strobe_mem, ~n_rb[0])
        end
    end
    // Fresh word after every take, so a lost or doubled word would shift the stream
    always @(negedge clock_i) if (wd_took) wd_data_i <= wd_data_i + 16'h0001;
    task automatic req(input dbot_cmd_t c, input logic [DBOT_ADDR_W-1:0] a, input logic ch);
        int n;
        n = 0;
        @(negedge clock_i);
        req_valid_i = 1'b1;
        req_cmd_i = c;
        req_addr_i = a;
        req_chop_i = ch;
        #1;
        while (req_ready_o !== 1'b1 && n < 200) begin
            @(negedge clock_i);
            #1;
            n++;
        end
        `CHK(n < 200, 1'b1)
        @(posedge clock_i);
        t_acc = cyc;
        @(negedge clock_i);
        req_valid_i = 1'b0;
    endtask
    task automatic refused(input dbot_cmd_t c);
        @(negedge clock_i);
        req_valid_i = 1'b1;
        req_cmd_i = c;
        repeat (3) begin
            #1;
            `CHK(req_ready_o, 1'b0)
            @(negedge clock_i);
        end
        req_valid_i = 1'b0;
    endtask
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge clock_i);
        @(negedge clock_i);
        sys_rst_i = 1'b0;
        `CHK(burst_len_o, DBOT_BL_RESET)
        refused(DBOT_CMD_WRITE);
        refused(DBOT_CMD_PDE);
        wd_valid_i = 1'b1;
        repeat (6) @(negedge clock_i);
        `CHK(wd_ready_o, 1'b0)
        req(DBOT_CMD_ACT, 14'h0000, 1'b0);
        for (int i = 0; i < 6; i++) begin
            req(DBOT_CMD_MRS, {12'h000, mode_tab[i]}, 1'b0);
            beats = (mode_tab[i] == DBOT_BL_FIXED4 || (mode_tab[i] == DBOT_BL_OTF && i[0])) ? 4 : 8;
            repeat (2) @(negedge clock_i);
            `CHK(burst_len_o, mode_tab[i])
            n_cap = 0;
            n_rb = 0;
            req(DBOT_CMD_WRITE, {1'b0, ~i[0], 12'h000}, i[0]);
            tw = t_acc;
            req(DBOT_CMD_READ, {1'b0, ~i[0], 12'h000}, i[0]);
            `CHK(t_acc - tw >= WRITE_LATENCY + DBOT_BEATS8 + DBOT_WTR_CK, 1'b1)
            repeat (24) @(negedge clock_i);
            `CHK(n_cap, beats)
            `CHK(n_rb, beats)
        end
        n_cap = 0;
        req(DBOT_CMD_WRITE, 14'h0000, 1'b1);
        tw = t_acc;
        req(DBOT_CMD_PRE, 14'h0000, 1'b0);
        `CHK(t_acc - tw >= WRITE_LATENCY + DBOT_BEATS8 + DBOT_WR_CK, 1'b1)
        `CHK(n_cap, 4)
        req(DBOT_CMD_ACT, 14'h0000, 1'b0);
        req(DBOT_CMD_PDE, 14'h0000, 1'b0);
        repeat (8) @(negedge clock_i);
        `CHK(powered_down_o, 1'b1)
        `CHK(link.term_async, 1'b1)
        req(DBOT_CMD_PDX, 14'h0000, 1'b0);
        repeat (8) @(negedge clock_i);
        `CHK(powered_down_o, 1'b0)
        `CHK(link.term_async, 1'b0)
        wrap_up();
    end
endmodule
